// File: dv/lbe_exec_bench.sv
`timescale 1ns/1ps
module lbe_exec_bench;
  typedef struct packed {
    logic [7:0]  fpre;
    logic [7:0]  acc;
    logic [3:0]  flg;
    logic [13:0] ins;
    logic [7:0]  eacc;
    logic [3:0]  eflg;
    logic [7:0]  efile;
  } lbe_row_t;

  localparam lbe_row_t ROWS [14] = '{
    '{8'h00, 8'h0F, 4'h0, 14'h3E01, 8'h10, 4'h2, 8'h00},
    '{8'h00, 8'h01, 4'h0, 14'h3EFF, 8'h00, 4'h7, 8'h00},
    '{8'h22, 8'h11, 4'h7, 14'h0705, 8'h33, 4'h0, 8'h22},
    '{8'hF8, 8'h08, 4'h0, 14'h0785, 8'h08, 4'h7, 8'h00},
    '{8'hF0, 8'h3C, 4'h3, 14'h0505, 8'h30, 4'h3, 8'hF0},
    '{8'h0F, 8'hF0, 4'h3, 14'h0585, 8'hF0, 4'h7, 8'h00},
    '{8'h00, 8'hAA, 4'h0, 14'h3955, 8'h00, 4'h4, 8'h00},
    '{8'h00, 8'hFF, 4'h7, 14'h39FF, 8'hFF, 4'h3, 8'h00},
    '{8'hFF, 8'h00, 4'h5, 14'h1385, 8'h00, 4'h5, 8'h7F},
    '{8'h00, 8'h00, 4'h2, 14'h1405, 8'h00, 4'h2, 8'h01},
    '{8'h08, 8'h00, 4'h5, 14'h1985, 8'h00, 4'h5, 8'h08},
    '{8'h00, 8'h00, 4'h0, 14'h1985, 8'h00, 4'h8, 8'h00},
    '{8'h08, 8'h00, 4'h7, 14'h1D85, 8'h00, 4'hF, 8'h08},
    '{8'hF7, 8'h00, 4'h2, 14'h1D85, 8'h00, 4'h2, 8'hF7}
  };

  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic        on_timer = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [7:0]  pin_val  = 8'hA5;
  logic [31:0] prdata, r, c;
  logic        pready, pslverr, prescaler_clear, prescaler_on_timer, err;
  logic [7:0]  port_pins, clr_count;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          cyc         = 0;

  always #12.5 pclk = ~pclk;

  lbe_exec i_lbe_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .prescaler_on_timer(prescaler_on_timer),
    .prescaler_clear(prescaler_clear)
  );

  lbe_far_model i_lbe_far_model (
    .pclk(pclk), .presetn(presetn), .pin_val(pin_val), .on_timer(on_timer),
    .prescaler_clear(prescaler_clear), .port_pins(port_pins),
    .prescaler_on_timer(prescaler_on_timer), .clr_count_ff(clr_count)
  );

  ////////////////////////////////
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // The bench never assumes a latency; instruction writes wait for the next tick.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, r);
  endtask : rd

  ////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 32'h0, "acc_rst");
    rd(12'h008, 32'h0, "flags_rst");
    rd(12'h214, 32'h0, "file_rst");
    foreach (ROWS[i]) begin
      apb(1'b1, 12'h214, {24'h0, ROWS[i].fpre});
      apb(1'b1, 12'h004, {24'h0, ROWS[i].acc});
      apb(1'b1, 12'h008, {28'h0, ROWS[i].flg});
      apb(1'b1, 12'h000, {18'h0, ROWS[i].ins});
      rd(12'h004, {24'h0, ROWS[i].eacc}, "acc");
      rd(12'h008, {28'h0, ROWS[i].eflg}, "flags");
      rd(12'h214, {24'h0, ROWS[i].efile}, "file");
      apb(1'b1, 12'h000, 32'h00003E01);
      apb(1'b0, 12'h004, 32'h0);
      chk("next_acc", {24'h0, ROWS[i].eacc + (ROWS[i].eflg[3] ? 8'h00 : 8'h01)}, r);
      apb(1'b0, 12'h008, 32'h0);
      chk("skip_flag", 32'h0, r & 32'h8);
    end
    apb(1'b1, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b0, 12'h202, 32'h0);
    chk("misaligned", 32'h1, {31'h0, err});
    apb(1'b1, 12'h218, 32'h0);
    apb(1'b1, 12'h000, 32'h00001486);
    rd(12'h218, 32'hA7, "port_latch");
    on_timer <= 1'b1;
    apb(1'b1, 12'h000, 32'h00001401);
    on_timer <= 1'b0;
    apb(1'b1, 12'h000, 32'h00001401);
    chk("clears", 32'h1, {24'h0, clr_count});
    rd(12'h000, 32'h1401, "instr_last");
    // Every instruction write counts one cycle, a discarded one included.
    rd(12'h00C, 32'h1F, "cycles");
    c = r;
    apb(1'b1, 12'h00C, 32'hFF);
    rd(12'h00C, c, "cycle_ro");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 32'h0, "acc_rerst");
    rd(12'h00C, 32'h0, "cycle_rerst");
    close_out();
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      close_out();
    end
  end
endmodule : lbe_exec_bench

// File: dv/lbe_exec_properties.sv
`timescale 1ns/1ps
module lbe_exec_checker #(
  parameter int CLKS_PER_CYC = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_pins,
  input wire logic        prescaler_on_timer,
  input wire logic        prescaler_clear
);
  // An instruction write waits for the next tick and answers one cycle after it.
  localparam int INSTR_MAX = CLKS_PER_CYC + 1;
  logic mapped;

  // Aligned control words and the file register window are the only decoded places.
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:4] == 8'h00 || paddr[11:9] == 3'h1);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  AST_REG_ANSWER: assert property (psel && $rose(penable) && paddr != 12'h000 |=> pready)
    else $error("register access not answered next cycle");
  AST_INSTR_ANSWER: assert property (
    psel && $rose(penable) && pwrite && paddr == 12'h000 |-> ##[2:INSTR_MAX] pready)
    else $error("instruction not retired within one instruction cycle");
  AST_ERR_DECODE: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address decode");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without pready");
  AST_CLR_CAUSE: assert property (prescaler_clear |-> pready && pwrite && paddr == 12'h000)
    else $error("prescaler clear without an instruction");
  AST_CLR_ENABLE: assert property (prescaler_clear |-> $past(prescaler_on_timer))
    else $error("prescaler clear while not assigned to timer");

  COV_ERR: cover property (pslverr);
  COV_CLR: cover property (prescaler_clear);
  COV_INSTR: cover property (pready && pwrite && paddr == 12'h000);
endmodule : lbe_exec_checker

bind lbe_exec lbe_exec_checker #(.CLKS_PER_CYC(CLKS_PER_CYC)) i_lbe_exec_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_pins(port_pins), .prescaler_on_timer(prescaler_on_timer),
  .prescaler_clear(prescaler_clear)
);

// File: dv/lbe_far_model.sv
`timescale 1ns/1ps
module lbe_far_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] pin_val,
  input  wire logic       on_timer,
  input  wire logic       prescaler_clear,
  output logic      [7:0] port_pins,
  output logic            prescaler_on_timer,
  output logic      [7:0] clr_count_ff
);
  logic [7:0] nxt_clr_count;

  assign port_pins          = pin_val;
  assign prescaler_on_timer = on_timer;
  assign nxt_clr_count      = clr_count_ff + {7'h00, prescaler_clear};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_count_ff <= 8'h00;
    end else begin
      clr_count_ff <= nxt_clr_count;
    end
  end
endmodule : lbe_far_model

// File: src/lbe_alu.sv
`timescale 1ns/1ps
module lbe_alu (
  lbe_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] mask;

  always_comb begin
    sum  = {1'b0, a.acc} + {1'b0, a.opnd};
    half = {1'b0, a.acc[3:0]} + {1'b0, a.opnd[3:0]};
    mask = 8'h01 << a.bit_idx;
    case (a.op)
      lbe_pkg::LBE_OP_ADD:  a.result = sum[7:0];
      lbe_pkg::LBE_OP_AND:  a.result = a.acc & a.opnd;
      lbe_pkg::LBE_OP_BCLR: a.result = a.opnd & ~mask;  // see RL5
      lbe_pkg::LBE_OP_BSET: a.result = a.opnd | mask;   // see RL6
      default:              a.result = a.opnd;
    endcase
    a.carry   = sum[8];                // see RL12
    a.dcarry  = half[4];               // see RL12
    a.zero    = (a.result == 8'h00);   // see RL12
    a.bit_val = |(a.opnd & mask);
  end
endmodule : lbe_alu

// File: src/lbe_alu_if.sv
`timescale 1ns/1ps
interface lbe_alu_if;
  lbe_pkg::lbe_op_t op;
  logic [7:0]       acc;
  logic [7:0]       opnd;
  logic [2:0]       bit_idx;
  logic [7:0]       result;
  logic             carry;
  logic             dcarry;
  logic             zero;
  logic             bit_val;

  modport alu  (input op, acc, opnd, bit_idx, output result, carry, dcarry, zero, bit_val);
  modport ctrl (output op, acc, opnd, bit_idx, input result, carry, dcarry, zero, bit_val);
endinterface : lbe_alu_if

// File: src/lbe_exec.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
// How it works
// RL1: Immediate add sums accumulator and literal into accumulator; carry, digit carry, zero update.
// RL2: File add sums accumulator and file register; destination bit picks target; carry, digit carry, zero update.
// RL3: File AND routes result by destination bit; only zero flag changes.
// RL4: Immediate AND puts result in accumulator; only zero flag changes.
// RL5: Bit clear zeroes the indexed bit of a file register; flags untouched.
// RL6: Bit set forces the indexed bit of a file register; flags untouched.
// RL7: Skip-when-one discards the next instruction as a no-operation if the bit is one.
// RL8: Skip-when-zero discards the next instruction as a no-operation if the bit is zero.
// RL9: A taken skip costs two instruction cycles, the second a no-operation.
// RL10: Self-modifying operations on the port register read the pin levels.
// RL11: Modifying the timer count register clears its prescaler when assigned there.
// RL12: Zero means an 8-bit zero result; carries leave bit 7 and bit 3.
module lbe_exec #(
  parameter int         CLKS_PER_CYC = lbe_pkg::LBE_CLKS_PER_CYC,
  parameter logic [6:0] PORT_ADDR    = lbe_pkg::LBE_PORT_ADDR,
  parameter logic [6:0] TIMER_ADDR   = lbe_pkg::LBE_TIMER_ADDR
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_pins,
  input  wire logic        prescaler_on_timer,
  output logic             prescaler_clear
);

  localparam int DIV_W = (CLKS_PER_CYC > 1) ? $clog2(CLKS_PER_CYC) : 1;

  if (CLKS_PER_CYC < 2) begin : g_bad_div
    $error("CLKS_PER_CYC must be at least 2");
  end

  typedef enum logic [1:0] {
    LBE_ST_IDLE,
    LBE_ST_WAIT,
    LBE_ST_RESP
  } lbe_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle divider.

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic             cyc_tick;

  always_comb begin
    cyc_tick = (div_ff == DIV_W'(CLKS_PER_CYC - 1));
    nxt_div  = cyc_tick ? '0 : div_ff + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the pending instruction and bus address.

  lbe_alu_if alu_bus ();

  lbe_alu u_alu (
    .a (alu_bus.alu)
  );

  lbe_state_t  state_ff;
  lbe_state_t  nxt_state;
  logic [7:0]  acc_ff;
  logic [7:0]  nxt_acc;
  logic [2:0]  flags_ff;
  logic [2:0]  nxt_flags;
  logic        skip_ff;
  logic        nxt_skip;
  logic [13:0] instr_ff;
  logic [13:0] nxt_instr;
  logic [31:0] cycles_ff;
  logic [31:0] nxt_cycles;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        presc_clr_ff;
  logic        nxt_presc_clr;
  logic [7:0]  file_mem [128];
  logic        mem_we;
  logic [6:0]  mem_wa;
  logic [7:0]  mem_wd;

  logic [13:0] iw;
  logic [6:0]  fa;
  logic        dest_file;
  logic [7:0]  file_opnd;
  logic        is_file_add;
  logic        is_file_and;
  logic        is_bit_grp;
  logic        is_imm_add;
  logic        is_imm_and;
  logic        file_region;
  logic [6:0]  bus_fa;
  logic        bus_hit;

  always_comb begin
    iw          = pwdata[13:0];
    fa          = iw[6:0];
    dest_file   = iw[7];
    is_file_add = (iw[13:8] == lbe_pkg::LBE_OPC_ADD_FILE);
    is_file_and = (iw[13:8] == lbe_pkg::LBE_OPC_AND_FILE);
    is_bit_grp  = (iw[13:12] == lbe_pkg::LBE_GRP_BIT);
    is_imm_add  = (iw[13:9] == lbe_pkg::LBE_OPC_ADD_IMM);
    is_imm_and  = (iw[13:8] == lbe_pkg::LBE_OPC_AND_IMM);
    // Port register operands come from the pins, not the output latch.
    file_opnd   = (fa == PORT_ADDR) ? port_pins : file_mem[fa];  // see RL10
    file_region = (paddr[11:9] == lbe_pkg::LBE_FILE_BASE_HI) && (paddr[1:0] == 2'h0);
    bus_fa      = paddr[8:2];
    bus_hit     = file_region || (paddr == lbe_pkg::LBE_ADDR_INSTR)
                  || (paddr == lbe_pkg::LBE_ADDR_ACC) || (paddr == lbe_pkg::LBE_ADDR_FLAGS)
                  || (paddr == lbe_pkg::LBE_ADDR_CYCLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and execution.

  always_comb begin
    nxt_state       = state_ff;
    nxt_acc         = acc_ff;
    nxt_flags       = flags_ff;
    nxt_skip        = skip_ff;
    nxt_instr       = instr_ff;
    nxt_cycles      = cycles_ff;
    nxt_prdata      = prdata_ff;
    nxt_pready      = 1'b0;
    nxt_pslverr     = 1'b0;
    nxt_presc_clr   = 1'b0;
    mem_we          = 1'b0;
    mem_wa          = bus_fa;
    mem_wd          = pwdata[7:0];
    alu_bus.acc     = acc_ff;
    alu_bus.opnd    = is_bit_grp || is_file_add || is_file_and ? file_opnd : iw[7:0];
    alu_bus.bit_idx = iw[9:7];
    alu_bus.op      = lbe_pkg::LBE_OP_PASS;
    if (is_file_add || is_imm_add) begin
      alu_bus.op = lbe_pkg::LBE_OP_ADD;
    end else if (is_file_and || is_imm_and) begin
      alu_bus.op = lbe_pkg::LBE_OP_AND;
    end else if (is_bit_grp && iw[11:10] == lbe_pkg::LBE_BIT_CLR) begin
      alu_bus.op = lbe_pkg::LBE_OP_BCLR;
    end else if (is_bit_grp && iw[11:10] == lbe_pkg::LBE_BIT_SET) begin
      alu_bus.op = lbe_pkg::LBE_OP_BSET;
    end
    case (state_ff)
      LBE_ST_IDLE: begin
        if (psel && penable) begin
          if (pwrite && paddr == lbe_pkg::LBE_ADDR_INSTR) begin
            nxt_state = LBE_ST_WAIT;
          end else begin
            nxt_state   = LBE_ST_RESP;
            nxt_pready  = 1'b1;
            nxt_pslverr = !bus_hit;
            nxt_prdata  = 32'h0000_0000;
            if (pwrite) begin
              if (file_region) begin
                mem_we = 1'b1;
              end else if (paddr == lbe_pkg::LBE_ADDR_ACC) begin
                nxt_acc = pwdata[7:0];
              end else if (paddr == lbe_pkg::LBE_ADDR_FLAGS) begin
                nxt_flags = pwdata[2:0];
              end
            end else if (file_region) begin
              nxt_prdata = {24'h00_0000, file_mem[bus_fa]};
            end else if (paddr == lbe_pkg::LBE_ADDR_INSTR) begin
              nxt_prdata = {18'h0_0000, instr_ff};
            end else if (paddr == lbe_pkg::LBE_ADDR_ACC) begin
              nxt_prdata = {24'h00_0000, acc_ff};
            end else if (paddr == lbe_pkg::LBE_ADDR_FLAGS) begin
              nxt_prdata = {28'h000_0000, skip_ff, flags_ff};
            end else if (paddr == lbe_pkg::LBE_ADDR_CYCLE) begin
              nxt_prdata = cycles_ff;
            end
          end
        end
      end
      LBE_ST_WAIT: begin
        // The bus stalls until the next instruction cycle boundary.
        if (cyc_tick) begin
          nxt_state  = LBE_ST_RESP;
          nxt_pready = 1'b1;
          nxt_instr  = iw;
          nxt_cycles = cycles_ff + 32'h0000_0001;
          mem_wa     = fa;
          mem_wd     = alu_bus.result;
          if (skip_ff) begin
            // Second cycle of a taken skip: the word is dropped unexecuted.
            nxt_skip = 1'b0;  // see RL7, RL8, RL9
          end else if (is_imm_add || is_file_add) begin
            nxt_flags[lbe_pkg::LBE_FLAG_CARRY]  = alu_bus.carry;   // see RL1, RL2
            nxt_flags[lbe_pkg::LBE_FLAG_DCARRY] = alu_bus.dcarry;  // see RL1, RL2
            nxt_flags[lbe_pkg::LBE_FLAG_ZERO]   = alu_bus.zero;    // see RL1, RL2
            mem_we  = is_file_add && dest_file;                   // see RL2
            nxt_acc = mem_we ? acc_ff : alu_bus.result;           // see RL1, RL2
          end else if (is_imm_and || is_file_and) begin
            nxt_flags[lbe_pkg::LBE_FLAG_ZERO] = alu_bus.zero;      // see RL3, RL4
            mem_we  = is_file_and && dest_file;                   // see RL3
            nxt_acc = mem_we ? acc_ff : alu_bus.result;           // see RL3, RL4
          end else if (is_bit_grp) begin
            case (iw[11:10])
              lbe_pkg::LBE_BIT_CLR:       mem_we   = 1'b1;               // see RL5
              lbe_pkg::LBE_BIT_SET:       mem_we   = 1'b1;               // see RL6
              lbe_pkg::LBE_BIT_SKIP_ONE:  nxt_skip = alu_bus.bit_val;    // see RL7, RL9
              lbe_pkg::LBE_BIT_SKIP_ZERO: nxt_skip = !alu_bus.bit_val;   // see RL8, RL9
              default:                    nxt_skip = 1'b0;
            endcase
          end
          nxt_presc_clr = mem_we && (fa == TIMER_ADDR) && prescaler_on_timer;  // see RL11
        end
      end
      LBE_ST_RESP: begin
        nxt_state = LBE_ST_IDLE;
      end
      default: begin
        nxt_state = LBE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= LBE_ST_IDLE;
      acc_ff       <= lbe_pkg::LBE_ACC_RST;
      flags_ff     <= lbe_pkg::LBE_FLAGS_RST;
      skip_ff      <= 1'b0;
      instr_ff     <= lbe_pkg::LBE_INSTR_RST;
      cycles_ff    <= 32'h0000_0000;
      prdata_ff    <= 32'h0000_0000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      presc_clr_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      acc_ff       <= nxt_acc;
      flags_ff     <= nxt_flags;
      skip_ff      <= nxt_skip;
      instr_ff     <= nxt_instr;
      cycles_ff    <= nxt_cycles;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      presc_clr_ff <= nxt_presc_clr;
    end
  end

  // File registers clear at reset so that operands are never unknown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  always_comb begin
    prdata          = prdata_ff;
    pready          = pready_ff;
    pslverr         = pslverr_ff;
    prescaler_clear = presc_clr_ff;
  end

endmodule : lbe_exec

// File: src/lbe_pkg.sv
package lbe_pkg;

  // APB register byte addresses.
  localparam logic [11:0] LBE_ADDR_INSTR = 12'h000;
  localparam logic [11:0] LBE_ADDR_ACC   = 12'h004;
  localparam logic [11:0] LBE_ADDR_FLAGS = 12'h008;
  localparam logic [11:0] LBE_ADDR_CYCLE = 12'h00C;
  // File register f sits at byte address LBE_FILE_BASE + 4*f.
  localparam logic [2:0]  LBE_FILE_BASE_HI = 3'h1;

  // Flag register field positions and reset values.
  localparam int          LBE_FLAG_CARRY  = 0;
  localparam int          LBE_FLAG_DCARRY = 1;
  localparam int          LBE_FLAG_ZERO   = 2;
  localparam int          LBE_FLAG_SKIP   = 3;
  localparam logic [7:0]  LBE_ACC_RST     = 8'h00;
  localparam logic [2:0]  LBE_FLAGS_RST   = 3'h0;
  localparam logic [13:0] LBE_INSTR_RST   = 14'h0000;

  // Instruction word encodings.
  localparam int          LBE_INSTR_W       = 14;
  localparam logic [5:0]  LBE_OPC_ADD_FILE  = 6'h07;
  localparam logic [5:0]  LBE_OPC_AND_FILE  = 6'h05;
  localparam logic [5:0]  LBE_OPC_AND_IMM   = 6'h39;
  localparam logic [4:0]  LBE_OPC_ADD_IMM   = 5'h1F;
  localparam logic [1:0]  LBE_GRP_BIT       = 2'h1;
  localparam logic [1:0]  LBE_BIT_CLR       = 2'h0;
  localparam logic [1:0]  LBE_BIT_SET       = 2'h1;
  localparam logic [1:0]  LBE_BIT_SKIP_ZERO = 2'h2;
  localparam logic [1:0]  LBE_BIT_SKIP_ONE  = 2'h3;

  // Timing and special file addresses.
  localparam int          LBE_CLKS_PER_CYC  = 4;
  localparam logic [6:0]  LBE_PORT_ADDR     = 7'h06;
  localparam logic [6:0]  LBE_TIMER_ADDR    = 7'h01;

  typedef enum logic [2:0] {
    LBE_OP_ADD,
    LBE_OP_AND,
    LBE_OP_BCLR,
    LBE_OP_BSET,
    LBE_OP_PASS
  } lbe_op_t;

endpackage : lbe_pkg
